// ==== verilog/ddrio_element.sv ====
// Double-rate IO element with strobe capture and phase reference tracking
`timescale 1ns/1ps
`default_nettype none
module ddrio_element #(
	parameter logic [1:0] PIN_ROLE = ddrio_pkg::DDRIO_ROLE_DQ,
	parameter logic EDGE_BOTTOM = 1'b0,
	parameter int GROUP_WIDTH = ddrio_pkg::DDRIO_W_X8,
	parameter int PAIR_INDEX = 0,
	parameter logic INIT_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic strobe_clk,
	input wire logic sclr,
	input wire logic [ddrio_pkg::DDRIO_MODE_W-1:0] mode,
	input wire logic ce_out,
	input wire logic ce_in,
	input wire logic dout_a,
	input wire logic dout_b,
	input wire logic oe_in,
	input wire logic inv_dout_a,
	input wire logic inv_dout_b,
	input wire logic inv_oe,
	input wire logic inv_din,
	input wire logic pin_din,
	output logic pin_dout,
	output logic pin_oe,
	input wire logic ref_top,
	input wire logic ref_bottom,
	output logic din_hi,
	output logic din_lo,
	output logic din_valid,
	output logic [ddrio_pkg::DDRIO_DELAY_W-1:0] delay_top,
	output logic [ddrio_pkg::DDRIO_DELAY_W-1:0] delay_bottom,
	output logic [ddrio_pkg::DDRIO_DELAY_W-1:0] strobe_delay_word
);
	// ********************
	// Declarations
	// ********************
	localparam logic ROLE_IS_DQ = (PIN_ROLE == ddrio_pkg::DDRIO_ROLE_DQ);
	localparam logic ROLE_IS_DQS = (PIN_ROLE == ddrio_pkg::DDRIO_ROLE_DQS);

	logic clr;
	logic da_x;
	logic db_x;
	logic oe_x;
	logic out_mode;
	logic in_mode;
	logic bidir_mode;
	logic out_a_reg;
	logic out_b_reg;
	logic oe_rise_n_reg;
	logic oe_fall_n_reg;
	logic tgl_meta_reg;
	logic tgl_sync_reg;
	logic tgl_last_reg;
	logic pair_arrived;
	logic din_hi_reg;
	logic din_lo_reg;
	logic din_valid_reg;
	logic [ddrio_pkg::DDRIO_DELAY_W-1:0] delay_top_reg;
	logic [ddrio_pkg::DDRIO_DELAY_W-1:0] delay_bottom_reg;
	logic [ddrio_pkg::DDRIO_DELAY_W-1:0] strobe_delay_word_reg;
	logic [ddrio_pkg::DDRIO_DELAY_W-1:0] edge_word;

	ddrio_cap_if cap_bus ();
	ddrio_trk_if trk_top ();
	ddrio_trk_if trk_bottom ();

	// ********************
	// Input conditioning and mode decode
	// ********************

	// Per-input inversion
	assign da_x = dout_a ^ inv_dout_a;
	assign db_x = dout_b ^ inv_dout_b;
	assign oe_x = oe_in ^ inv_oe;

	// Shared clear for the output, enable, capture and pair registers; toggle synchroniser and delay words take rst only
	assign clr = rst | sclr;

	// Mode flags
	assign out_mode = (mode == ddrio_pkg::DDRIO_MODE_OUT) ||
		(mode == ddrio_pkg::DDRIO_MODE_BIDIR);
	assign in_mode = (mode == ddrio_pkg::DDRIO_MODE_IN) ||
		(mode == ddrio_pkg::DDRIO_MODE_BIDIR);
	assign bidir_mode = (mode == ddrio_pkg::DDRIO_MODE_BIDIR);

	// ********************
	// Output path
	// ********************

	// Output data registers on the shared output clock enable
	always_ff @(posedge clk) begin
		if (clr) begin
			out_a_reg <= INIT_VAL;
			out_b_reg <= INIT_VAL;
		end else if (ce_out) begin
			out_a_reg <= da_x;
			out_b_reg <= db_x;
		end
	end

	// Rising-edge enable register, stored active low
	always_ff @(posedge clk) begin
		if (clr) begin
			oe_rise_n_reg <= ddrio_pkg::DDRIO_OE_OFF_N;
		end else if (ce_out) begin
			oe_rise_n_reg <= ~(oe_x & out_mode);
		end
	end

	// Falling-edge enable register delays turn-on by half a cycle
	always_ff @(negedge clk) begin
		if (clr) begin
			oe_fall_n_reg <= ddrio_pkg::DDRIO_OE_OFF_N;
		end else begin
			oe_fall_n_reg <= oe_rise_n_reg;
		end
	end

	// Clock-muxed pin data, first bit while clock is high
	assign pin_dout = clk ? out_a_reg : out_b_reg;

	// Pad enable: bidirectional mode waits for the falling edge
	assign pin_oe = bidir_mode ? ~oe_fall_n_reg : ~oe_rise_n_reg;

	// ********************
	// Input path
	// ********************

	// Strobe-clocked capture on the local strobe bus
	ddrio_strobe_capture #(
		.INIT_VAL(INIT_VAL)
	) u_capture (
		.strobe_clk(strobe_clk),
		.rst(clr),
		.ce_in(ce_in),
		.inv_din(inv_din),
		.din_pin(pin_din),
		.cap(cap_bus.src)
	);

	// Pair toggle synchroniser into the fabric clock
	always_ff @(posedge clk) begin
		if (rst) begin
			tgl_meta_reg <= 1'b0;
			tgl_sync_reg <= 1'b0;
			tgl_last_reg <= 1'b0;
		end else begin
			tgl_meta_reg <= cap_bus.tgl;
			tgl_sync_reg <= tgl_meta_reg;
			tgl_last_reg <= tgl_sync_reg;
		end
	end
	assign pair_arrived = tgl_sync_reg ^ tgl_last_reg;

	// Take the held pair; only a DQ pin may use strobe data
	always_ff @(posedge clk) begin
		if (clr) begin
			din_hi_reg <= INIT_VAL;
			din_lo_reg <= INIT_VAL;
			din_valid_reg <= 1'b0;
		end else begin
			din_valid_reg <= 1'b0;
			if (pair_arrived && in_mode && ROLE_IS_DQ) begin
				din_hi_reg <= cap_bus.hi;
				din_lo_reg <= cap_bus.lo;
				din_valid_reg <= 1'b1;
			end
		end
	end
	assign din_hi = din_hi_reg;
	assign din_lo = din_lo_reg;
	assign din_valid = din_valid_reg;

	// ********************
	// Strobe delay control
	// ********************

	// One reference tracker per device edge
	ddrio_ref_tracker u_trk_top (
		.clk(clk),
		.rst(rst),
		.ref_pin(ref_top),
		.trk(trk_top.src)
	);
	ddrio_ref_tracker u_trk_bottom (
		.clk(clk),
		.rst(rst),
		.ref_pin(ref_bottom),
		.trk(trk_bottom.src)
	);

	// Word of this element's own edge
	assign edge_word = EDGE_BOTTOM ? trk_bottom.word : trk_top.word;

	// Broadcast words and this pin's compensated delay setting
	always_ff @(posedge clk) begin
		if (rst) begin
			delay_top_reg <= '0;
			delay_bottom_reg <= '0;
			strobe_delay_word_reg <= '0;
		end else begin
			delay_top_reg <= trk_top.word;
			delay_bottom_reg <= trk_bottom.word;
			strobe_delay_word_reg <= ROLE_IS_DQS ? edge_word : '0;
		end
	end
	assign delay_top = delay_top_reg;
	assign delay_bottom = delay_bottom_reg;
	assign strobe_delay_word = strobe_delay_word_reg;

	// ********************
	// Assertions
	// ********************

	property p_out_load;
		@(posedge clk) disable iff (clr)
		ce_out |=> (out_a_reg == $past(da_x)) && (out_b_reg == $past(db_x));
	endproperty
	a_out_load: assert property (p_out_load) else $error("output load wrong");

	property p_ce_hold;
		@(posedge clk) disable iff (clr)
		!ce_out |=> $stable(out_a_reg) && $stable(out_b_reg) && $stable(oe_rise_n_reg);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("shared enable ignored");

	property p_oe_inv;
		@(posedge clk) disable iff (clr)
		(ce_out && out_mode) |=> oe_rise_n_reg == !$past(oe_x);
	endproperty
	a_oe_inv: assert property (p_oe_inv) else $error("enable polarity wrong");

	property p_oe_fall;
		@(negedge clk) disable iff (clr)
		1'b1 |=> oe_fall_n_reg == $past(oe_rise_n_reg);
	endproperty
	a_oe_fall: assert property (p_oe_fall) else $error("negedge enable wrong");

	property p_pin_high;
		@(negedge clk) disable iff (rst)
		pin_dout == out_a_reg;
	endproperty
	a_pin_high: assert property (p_pin_high) else $error("first bit missing");

	property p_pin_low;
		@(posedge clk) disable iff (rst)
		pin_dout == out_b_reg;
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("second bit missing");

	property p_in_off;
		@(posedge clk) disable iff (clr)
		(!ROLE_IS_DQ || !in_mode) |=> !din_valid_reg;
	endproperty
	a_in_off: assert property (p_in_off) else $error("capture on wrong pin");

	property p_pair_take;
		@(posedge clk) disable iff (clr)
		(pair_arrived && in_mode && ROLE_IS_DQ) |=>
			din_valid_reg && (din_hi_reg == $past(cap_bus.hi)) &&
			(din_lo_reg == $past(cap_bus.lo));
	endproperty
	a_pair_take: assert property (p_pair_take) else $error("pair lost");

	property p_delay_sel;
		@(posedge clk) disable iff (rst)
		1'b1 |=> strobe_delay_word_reg == (ROLE_IS_DQS ? $past(edge_word) : '0);
	endproperty
	a_delay_sel: assert property (p_delay_sel) else $error("strobe delay wrong");

	property p_width_ok;
		@(posedge clk) ddrio_pkg::ddrio_width_ok(GROUP_WIDTH);
	endproperty
	a_width_ok: assert property (p_width_ok) else $error("illegal group width");

	property p_pair_ok;
		@(posedge clk) (PAIR_INDEX >= 0) && (PAIR_INDEX < ddrio_pkg::DDRIO_PAIRS_MAX) &&
			(ddrio_pkg::DDRIO_PAIRS_RIGHT + ddrio_pkg::DDRIO_PAIRS_LEFT ==
			ddrio_pkg::DDRIO_PAIRS_MAX);
	endproperty
	a_pair_ok: assert property (p_pair_ok) else $error("strobe pair index too big");

	// Clear reaches the output, enable and pair registers; enable loads off on ce_out outside output modes
	property p_clr_all;
		@(posedge clk)
		clr |=> (out_a_reg == INIT_VAL) && (out_b_reg == INIT_VAL) &&
			(oe_rise_n_reg == ddrio_pkg::DDRIO_OE_OFF_N) && !din_valid_reg;
	endproperty
	a_clr_all: assert property (p_clr_all) else $error("clear missed a register");

	property p_oe_mode_off;
		@(posedge clk) disable iff (clr)
		(ce_out && !out_mode) |=> oe_rise_n_reg == ddrio_pkg::DDRIO_OE_OFF_N;
	endproperty
	a_oe_mode_off: assert property (p_oe_mode_off) else $error("enable on in input mode");

	// Pair pulse lasts one cycle; held pair only moves on a new arrival
	property p_valid_pulse;
		@(posedge clk) disable iff (clr)
		din_valid_reg |=> !din_valid_reg;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("pair pulse too long");

	property p_in_hold;
		@(posedge clk) disable iff (clr)
		!pair_arrived |=> $stable(din_hi_reg) && $stable(din_lo_reg);
	endproperty
	a_in_hold: assert property (p_in_hold) else $error("held pair changed");

	// Main scenarios
	c_turn_on: cover property (@(posedge clk) disable iff (clr)
		bidir_mode && $rose(pin_oe));
	c_pair_in: cover property (@(posedge clk) disable iff (clr) din_valid_reg);
	c_out_load: cover property (@(posedge clk) disable iff (clr)
		ce_out && (da_x != db_x));
	c_track: cover property (@(posedge clk) disable iff (rst) trk_top.upd);
endmodule // ddrio_element
`default_nettype wire

// ==== verilog/ddrio_pkg.sv ====
// Shared constants and types for the double-rate IO element
`default_nettype none
package ddrio_pkg;
	// ********************
	// Modes and pin roles
	// ********************
	localparam int DDRIO_MODE_W = 2;
	localparam logic [1:0] DDRIO_MODE_IN = 2'h0;
	localparam logic [1:0] DDRIO_MODE_OUT = 2'h1;
	localparam logic [1:0] DDRIO_MODE_BIDIR = 2'h2;
	localparam logic [1:0] DDRIO_ROLE_PLAIN = 2'h0;
	localparam logic [1:0] DDRIO_ROLE_DQ = 2'h1;
	localparam logic [1:0] DDRIO_ROLE_DQS = 2'h2;
	// ********************
	// Element structure
	// ********************
	localparam int DDRIO_REG_COUNT = 6;
	localparam logic DDRIO_OE_OFF_N = 1'b1;
	// ********************
	// Strobe grouping limits
	// ********************
	localparam int DDRIO_PAIRS_MAX = 18;
	localparam int DDRIO_PAIRS_RIGHT = 10;
	localparam int DDRIO_PAIRS_LEFT = 8;
	localparam int DDRIO_W_X4 = 4;
	localparam int DDRIO_W_X8 = 8;
	localparam int DDRIO_W_X9 = 9;
	localparam int DDRIO_W_X16 = 16;
	localparam int DDRIO_W_X18 = 18;
	localparam int DDRIO_W_X32 = 32;
	localparam int DDRIO_W_X36 = 36;
	// ********************
	// Phase reference tracking
	// ********************
	localparam int DDRIO_CNT_W = 10;
	localparam int DDRIO_DELAY_SHIFT = 2;
	localparam int DDRIO_DELAY_W = DDRIO_CNT_W - DDRIO_DELAY_SHIFT;
	localparam logic [DDRIO_CNT_W-1:0] DDRIO_CNT_MAX = 10'h3ff;
	typedef enum logic [1:0] {
		DDRIO_TRK_WAIT = 2'h1,
		DDRIO_TRK_RUN = 2'h2
	} ddrio_trk_t;
	// Legal data group widths
	function automatic bit ddrio_width_ok(input int w);
		return (w == DDRIO_W_X4) || (w == DDRIO_W_X8) || (w == DDRIO_W_X9) ||
			(w == DDRIO_W_X16) || (w == DDRIO_W_X18) || (w == DDRIO_W_X32) ||
			(w == DDRIO_W_X36);
	endfunction
endpackage
`default_nettype wire

// ==== verilog/ddrio_if.sv ====
// Internal carriers: strobe capture pair and phase tracker word
`timescale 1ns/1ps
`default_nettype none
interface ddrio_cap_if;
	logic hi;
	logic lo;
	logic tgl;
	modport src (output hi, output lo, output tgl);
	modport dst (input hi, input lo, input tgl);
endinterface : ddrio_cap_if

interface ddrio_trk_if;
	logic [ddrio_pkg::DDRIO_DELAY_W-1:0] word;
	logic upd;
	modport src (output word, output upd);
	modport dst (input word, input upd);
endinterface : ddrio_trk_if
`default_nettype wire

// ==== verilog/ddrio_ref_tracker.sv ====
// Phase-shift reference tracker producing a strobe delay word
`timescale 1ns/1ps
`default_nettype none
module ddrio_ref_tracker (
	input wire logic clk,
	input wire logic rst,
	input wire logic ref_pin,
	ddrio_trk_if.src trk
);
	logic ref_meta_reg;
	logic ref_sync_reg;
	logic ref_last_reg;
	logic ref_rise;
	logic [ddrio_pkg::DDRIO_CNT_W-1:0] cnt_reg;
	logic [ddrio_pkg::DDRIO_DELAY_W-1:0] cnt_quarter;
	logic [ddrio_pkg::DDRIO_DELAY_W-1:0] word_reg;
	logic upd_reg;
	ddrio_pkg::ddrio_trk_t state_reg;

	// Reference pin synchroniser and edge detect
	always_ff @(posedge clk) begin
		if (rst) begin
			ref_meta_reg <= 1'b0;
			ref_sync_reg <= 1'b0;
			ref_last_reg <= 1'b0;
		end else begin
			ref_meta_reg <= ref_pin;
			ref_sync_reg <= ref_meta_reg;
			ref_last_reg <= ref_sync_reg;
		end
	end
	assign ref_rise = ref_sync_reg & ~ref_last_reg;
	assign cnt_quarter = cnt_reg[ddrio_pkg::DDRIO_CNT_W-1:ddrio_pkg::DDRIO_DELAY_SHIFT];

	// Period counter, saturating
	always_ff @(posedge clk) begin
		if (rst || ref_rise) begin
			cnt_reg <= '0;
		end else if (cnt_reg != ddrio_pkg::DDRIO_CNT_MAX) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

	// Lock state and quarter-period word broadcast
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= ddrio_pkg::DDRIO_TRK_WAIT;
			word_reg <= '0;
			upd_reg <= 1'b0;
		end else begin
			upd_reg <= 1'b0;
			unique case (state_reg)
				ddrio_pkg::DDRIO_TRK_WAIT: begin
					if (ref_rise) begin
						state_reg <= ddrio_pkg::DDRIO_TRK_RUN;
					end
				end
				ddrio_pkg::DDRIO_TRK_RUN: begin
					if (ref_rise) begin
						word_reg <= cnt_quarter;
						upd_reg <= 1'b1;
					end
				end
			endcase
		end
	end
	assign trk.word = word_reg;
	assign trk.upd = upd_reg;

	property p_word_track;
		@(posedge clk) disable iff (rst)
		(state_reg == ddrio_pkg::DDRIO_TRK_RUN && ref_rise) |=>
			(word_reg == $past(cnt_quarter)) && upd_reg;
	endproperty
	a_word_track: assert property (p_word_track) else $error("delay word not updated");
endmodule // ddrio_ref_tracker
`default_nettype wire

// ==== verilog/ddrio_strobe_capture.sv ====
// Strobe-clocked input capture: rise register, fall register, hold latch
`timescale 1ns/1ps
`default_nettype none
module ddrio_strobe_capture #(
	parameter logic INIT_VAL = 1'b0
) (
	input wire logic strobe_clk,
	input wire logic rst,
	input wire logic ce_in,
	input wire logic inv_din,
	input wire logic din_pin,
	ddrio_cap_if.src cap
);
	logic [2:0] ctl_meta_reg;
	logic [2:0] ctl_sync_reg;
	logic srst;
	logic ce_s;
	logic inv_s;
	logic din_x;
	logic rise_reg;
	logic fall_reg;
	logic latch_reg;
	logic tgl_reg;

	// Control levels into the strobe domain
	always_ff @(posedge strobe_clk) begin
		ctl_meta_reg <= {rst, ce_in, inv_din};
		ctl_sync_reg <= ctl_meta_reg;
	end
	assign srst = ctl_sync_reg[2];
	assign ce_s = ctl_sync_reg[1];
	assign inv_s = ctl_sync_reg[0];
	assign din_x = din_pin ^ inv_s;

	// Rising-edge capture
	always_ff @(posedge strobe_clk) begin
		if (srst) begin
			rise_reg <= INIT_VAL;
		end else if (ce_s) begin
			rise_reg <= din_x;
		end
	end

	// Falling-edge capture; latch keeps the high-phase bit
	always_ff @(negedge strobe_clk) begin
		if (srst) begin
			fall_reg <= INIT_VAL;
			latch_reg <= INIT_VAL;
			tgl_reg <= 1'b0;
		end else if (ce_s) begin
			fall_reg <= din_x;
			latch_reg <= rise_reg;
			tgl_reg <= ~tgl_reg;
		end
	end
	assign cap.hi = latch_reg;
	assign cap.lo = fall_reg;
	assign cap.tgl = tgl_reg;

	property p_rise_cap;
		@(posedge strobe_clk) disable iff (srst)
		ce_s |=> rise_reg == $past(din_x);
	endproperty
	a_rise_cap: assert property (p_rise_cap) else $error("rise capture wrong");

	property p_pair_align;
		@(negedge strobe_clk) disable iff (srst)
		ce_s |=> (latch_reg == $past(rise_reg)) && (fall_reg == $past(din_x)) &&
			(tgl_reg != $past(tgl_reg));
	endproperty
	a_pair_align: assert property (p_pair_align) else $error("pair not aligned");
endmodule // ddrio_strobe_capture
`default_nettype wire

// ==== dv/ddrio_mem_model.sv ====
// Behavioural external memory: data and strobe source, reference clocks
`timescale 1ns/1ps
`default_nettype none
module ddrio_mem_model #(
	parameter int STROBE_NS = 160,
	parameter int REF_BOT_NS = 240
) (
	output logic dq,
	output logic dqs,
	output logic ref_top,
	output logic ref_bottom
);
	// ********************
	// Idle levels and reference clocks
	// ********************
	// Strobe stands still low outside frames
	initial begin
		dq = 1'b0;
		dqs = 1'b0;
	end

	// Top reference from a dedicated clock pin at the strobe rate
	initial begin
		ref_top = 1'b0;
		#1.3;
		forever #(STROBE_NS / 2) ref_top = ~ref_top;
	end

	// Bottom reference from its own dedicated clock pin
	initial begin
		ref_bottom = 1'b0;
		#2.7;
		forever #(REF_BOT_NS / 2) ref_bottom = ~ref_bottom;
	end

	// ********************
	// Read burst
	// ********************
	// One pair: first bit around strobe rise, second around strobe fall
	task automatic send_pair(input logic d0, input logic d1);
		dq = d0;
		#(STROBE_NS / 4) dqs = 1'b1;
		#(STROBE_NS / 4) dq = d1;
		#(STROBE_NS / 4) dqs = 1'b0;
		// Released, no keeper: shows the inverse until the next pair
		#(STROBE_NS / 8) dq = ~d1;
		#(STROBE_NS / 8);
	endtask
endmodule // ddrio_mem_model
`default_nettype wire

// ==== dv/tb_top.sv ====
// Self-checking bench for the double-rate IO element
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int REF_TOP_NS = 160;
	localparam int REF_BOT_NS = 240;
	localparam int CLK_NS = 4;
	localparam int LIMIT = 12000;
	logic clk, rst, sclr, ce_out, ce_in, dout_a, dout_b, oe_in;
	logic inv_dout_a, inv_dout_b, inv_oe, inv_din, pin_wire;
	logic [1:0] mode;
	logic pin_dout, pin_oe, din_hi, din_lo, din_valid, dqs_valid;
	logic [ddrio_pkg::DDRIO_DELAY_W-1:0] delay_top, delay_bottom, dly_word, dqs_word;
	logic mem_dq, mem_dqs, ref_top, ref_bottom;
	logic ea, eb, eo, eo_fall;
	logic [31:0] rng_state;
	logic [1:0] obs_q[$];
	logic [1:0] exp_q[$];
	int err_count, num_checks, cycles, dqs_pulses;

	// ********************
	// Pin, partner and elements
	// ********************
	// Shared data wire: element drives while enabled, else the memory
	assign pin_wire = pin_oe ? pin_dout : mem_dq;

	ddrio_mem_model #(.STROBE_NS(REF_TOP_NS), .REF_BOT_NS(REF_BOT_NS)) mem (
		.dq(mem_dq), .dqs(mem_dqs), .ref_top(ref_top), .ref_bottom(ref_bottom));

	ddrio_element dut (
		.clk(clk), .rst(rst), .strobe_clk(mem_dqs), .sclr(sclr), .mode(mode),
		.ce_out(ce_out), .ce_in(ce_in), .dout_a(dout_a), .dout_b(dout_b), .oe_in(oe_in),
		.inv_dout_a(inv_dout_a), .inv_dout_b(inv_dout_b), .inv_oe(inv_oe),
		.inv_din(inv_din), .pin_din(pin_wire), .pin_dout(pin_dout), .pin_oe(pin_oe),
		.ref_top(ref_top), .ref_bottom(ref_bottom), .din_hi(din_hi), .din_lo(din_lo),
		.din_valid(din_valid), .delay_top(delay_top), .delay_bottom(delay_bottom),
		.strobe_delay_word(dly_word));

	// Strobe pin element on the bottom edge; its capture samples the data
	// line so the strobe never samples itself
	ddrio_element #(.PIN_ROLE(ddrio_pkg::DDRIO_ROLE_DQS), .EDGE_BOTTOM(1'b1)) dut_dqs (
		.clk(clk), .rst(rst), .strobe_clk(mem_dqs), .sclr(sclr), .mode(mode),
		.ce_out(ce_out), .ce_in(ce_in), .dout_a(dout_a), .dout_b(dout_b), .oe_in(oe_in),
		.inv_dout_a(inv_dout_a), .inv_dout_b(inv_dout_b), .inv_oe(inv_oe),
		.inv_din(inv_din), .pin_din(mem_dq), .pin_dout(), .pin_oe(),
		.ref_top(ref_top), .ref_bottom(ref_bottom), .din_hi(), .din_lo(),
		.din_valid(dqs_valid), .delay_top(), .delay_bottom(),
		.strobe_delay_word(dqs_word));

	// ********************
	// Helpers
	// ********************
	function automatic logic [31:0] rnd();
		rng_state ^= rng_state << 13;
		rng_state ^= rng_state >> 17;
		rng_state ^= rng_state << 5;
		return rng_state;
	endfunction

	function automatic logic exp_oe(input logic oe, input logic inv, input logic [1:0] m);
		return (oe ^ inv) & ((m == ddrio_pkg::DDRIO_MODE_OUT) || (m == ddrio_pkg::DDRIO_MODE_BIDIR));
	endfunction

	function automatic logic [7:0] exp_word(input int period_ns);
		return 8'(((period_ns / CLK_NS) - 1) >> ddrio_pkg::DDRIO_DELAY_SHIFT);
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Random output traffic; high phase and low phase checked each cycle after the first
	task automatic out_cycles(input logic [1:0] m, input int n);
		int k;
		logic [31:0] r;
		@(posedge clk);
		#1;
		mode = m;
		for (k = 0; k < n; k++) begin
			@(posedge clk);
			#1;
			if (sclr) begin
				ea = 1'b0;
				eb = 1'b0;
				eo = 1'b0;
			end else if (ce_out) begin
				ea = dout_a ^ inv_dout_a;
				eb = dout_b ^ inv_dout_b;
				eo = exp_oe(oe_in, inv_oe, m);
			end
			if (k > 0) check(pin_dout, ea);
			if (k > 0) check(pin_oe, (m == ddrio_pkg::DDRIO_MODE_BIDIR) ? eo_fall : eo);
			r = rnd();
			ce_out = (r[2:0] != 3'h0);
			dout_a = r[3];
			dout_b = r[4];
			oe_in = r[5];
			inv_dout_a = r[6];
			inv_dout_b = r[7];
			inv_oe = r[8];
			sclr = (r[15:11] == 5'h00);
			if (sclr) ce_out = 1'b1;
			@(negedge clk);
			#1;
			// A clear seen at this falling edge empties the late enable register
			eo_fall = sclr ? 1'b0 : eo;
			if (k > 0) check(pin_dout, eb);
			if (k > 0) check(pin_oe, (m == ddrio_pkg::DDRIO_MODE_BIDIR) ? eo_fall : eo);
		end
	endtask

	// Read burst of n pairs from the memory; kept pairs are expected
	task automatic frame(input int n, input logic keep);
		int i;
		logic [31:0] r;
		for (i = 0; i < n; i++) begin
			r = rnd();
			mem.send_pair(r[0], r[1]);
			if (keep) exp_q.push_back({r[0] ^ inv_din, r[1] ^ inv_din});
		end
		repeat (8) @(posedge clk);
		#1;
	endtask

	task automatic compare_in();
		int i;
		check(obs_q.size(), exp_q.size());
		for (i = 0; i < obs_q.size() && i < exp_q.size(); i++) begin
			check(obs_q[i], exp_q[i]);
		end
		obs_q.delete();
		exp_q.delete();
	endtask

	// ********************
	// Clock, monitors, timeout
	// ********************
	initial begin
		clk = 1'b0;
		forever #(CLK_NS / 2) clk = ~clk;
	end

	// Collect captured pairs and any pulse from the strobe pin element
	always @(posedge clk) begin
		if (!rst && din_valid === 1'b1) obs_q.push_back({din_hi, din_lo});
		if (!rst && dqs_valid !== 1'b0) dqs_pulses++;
	end

	// Cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			conclude();
		end
	end

	// ********************
	// Main sequence
	// ********************
	initial begin
		rng_state = 32'h00000060;
		{ce_out, dout_a, dout_b, oe_in, inv_dout_a, inv_dout_b, inv_oe, inv_din} = '0;
		ce_in = 1'b1;
		mode = ddrio_pkg::DDRIO_MODE_IN;
		rst = 1'b1;
		sclr = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		// Strobe runs under the element clear so its own domain is cleared too
		frame(4, 1'b0);
		sclr = 1'b0;
		repeat (2) @(posedge clk);
		obs_q.delete();
		dqs_pulses = 0;
		out_cycles(ddrio_pkg::DDRIO_MODE_OUT, 150);
		out_cycles(ddrio_pkg::DDRIO_MODE_BIDIR, 150);
		out_cycles(ddrio_pkg::DDRIO_MODE_IN, 60);
		out_cycles(2'h3, 30);
		@(posedge clk);
		#1;
		{sclr, oe_in, inv_oe} = '0;
		ce_out = 1'b1;
		// Capture plain, then inverted through the bidirectional path
		for (int v = 0; v < 2; v++) begin
			inv_din = v[0];
			mode = v[0] ? ddrio_pkg::DDRIO_MODE_BIDIR : ddrio_pkg::DDRIO_MODE_IN;
			frame(3, 1'b0);
			obs_q.delete();
			frame(16, 1'b1);
			compare_in();
		end
		// Output-only mode drops captured pairs
		mode = ddrio_pkg::DDRIO_MODE_OUT;
		frame(4, 1'b0);
		check(obs_q.size(), 0);
		check(delay_top, exp_word(REF_TOP_NS));
		check(delay_bottom, exp_word(REF_BOT_NS));
		check(dly_word, 0);
		check(dqs_word, exp_word(REF_BOT_NS));
		check(dqs_pulses, 0);
		conclude();
	end
endmodule // tb_top
`default_nettype wire
